// File: hdl/osk_pkg.sv
package osk_pkg;
	typedef enum logic [1:0] {SW_OFF, SW_WINDOW, SW_ANALOG, SW_LIMIT} osk_swmode_t;
	typedef enum logic [1:0] {DRV_NPN, DRV_PNP, DRV_PUSH, DRV_PUSH_INV} osk_drive_t;
	typedef enum logic [1:0] {SEL_WEB, SEL_SERIAL, SEL_ANALOG, SEL_RSVD} osk_sel_t;
	typedef enum logic [1:0] {LK_OFF, LK_ON, LK_AUTO, LK_RSVD} osk_lock_t;
	typedef enum {ST_BOOT, ST_RUN} osk_state_t;
endpackage : osk_pkg

// File: hdl/osk_regs.svh
// How it works
// R1 - window mode: peak outside window sets output
// R2 - limit mode: value above limit sets output
// R3 - analog mode: value outside range sets output
// R4 - one setting picks interface and LED colour
// R5 - serial and current never carry values together
// R6 - web selected: serial and current stay silent
// R7 - auto lock after 1 to 60 idle minutes
// R8 - refresh restarts the lock interval
// R9 - permanent lock ignores every key press
// R10 - inactive lock accepts every key press
// R11 - eight setup slots; load activates one
// R12 - save overwrites existing slot; delete clears
// R13 - favourite slot loaded after reboot
// R14 - device settings stored and reloaded
// R15 - unit setting picks millimetres or inches
// R16 - limit release below hysteresis, after hold
`ifndef OSK_REGS_SVH
`define OSK_REGS_SVH
`define OSK_CLK_HZ 50000000
`define OSK_MIN_SEC 60
`define OSK_LOCK_MIN_LO 6'h01
`define OSK_LOCK_MIN_HI 6'h3c
`define OSK_ADDR_W 8
`define OSK_A_CTRL 8'h00
`define OSK_A_LIMIT 8'h04
`define OSK_A_HOLD 8'h08
`define OSK_A_ARANGE 8'h0c
`define OSK_A_WINDOW 8'h10
`define OSK_A_LOCK 8'h14
`define OSK_A_CMD 8'h18
`define OSK_A_STATUS 8'h1c
`define OSK_A_MEAS 8'h20
`define OSK_A_ACTIVE 8'h24
`define OSK_CTRL_RST 32'h00000000
`define OSK_LOCK_RST 32'h00000001
`define OSK_F_MODE 1:0
`define OSK_F_DRIVE 3:2
`define OSK_F_SEL 5:4
`define OSK_F_INCH 6
`define OSK_F_LOCK 8:7
`define OSK_F_CTRL_W 9
`define OSK_F_LO 15:0
`define OSK_F_HI 31:16
`define OSK_F_MIN 5:0
`define OSK_C_REFRESH 0
`define OSK_C_LOAD 1
`define OSK_C_SAVE 2
`define OSK_C_DELETE 3
`define OSK_C_FAV 4
`define OSK_C_CREATE 5
`define OSK_C_DEV_SAVE 6
`define OSK_C_DEV_LOAD 7
`define OSK_C_SLOT 10:8
`define OSK_RESP_OKAY 2'h0
`define OSK_RESP_SLVERR 2'h2
`endif

// File: hdl/osk_setup_store.sv
`timescale 1ns/1ps
// retained storage; cleared by the power-on wipe and by slot delete, not by reboot
module osk_setup_store
	import osk_pkg::*;
#(
	parameter int SLOTS = 8,
	parameter int DW = 32,
	parameter int SW = $clog2(SLOTS)
)
(
	input wire logic i_clk, // system clock
	input wire logic i_wipe, // power-on clear of retained state
	input wire logic i_create, // write slot unconditionally
	input wire logic i_save, // overwrite an existing slot
	input wire logic i_delete, // clear slot
	input wire logic i_fav, // mark slot as favourite
	input wire logic [SW-1:0] i_slot, // selected slot
	input wire logic [DW-1:0] i_wdata, // settings to store
	input wire logic i_dev_save, // store device settings
	input wire logic [DW-1:0] i_dev_wdata, // device settings to store
	output logic [SLOTS-1:0] o_valid, // slot holds a setup
	output logic [SW-1:0] o_fav, // favourite slot
	output logic [DW-1:0] o_rd_data, // contents of selected slot
	output logic [DW-1:0] o_dev_data // stored device settings
);
	logic [DW-1:0] mem_q [SLOTS];
	logic [SLOTS-1:0] valid_q;
	logic [SW-1:0] fav_q;
	logic [DW-1:0] dev_q;

	if (SLOTS < 2 || (1 << SW) < SLOTS) begin : g_chk
		$error("osk_setup_store: bad slot count");
	end

	// R12 guarded overwrite
	always_ff @(posedge i_clk)
		if (i_create || (i_save && valid_q[i_slot]))
			mem_q[i_slot] <= i_wdata;

	// R12 valid and clear
	always_ff @(posedge i_clk)
		if (i_wipe)
			valid_q <= '0;
		else if (i_create)
			valid_q[i_slot] <= 1'b1;
		else if (i_delete)
			valid_q[i_slot] <= 1'b0;

	// R13 favourite mark
	always_ff @(posedge i_clk)
		if (i_wipe)
			fav_q <= '0;
		else if (i_fav)
			fav_q <= i_slot;

	// R14 device settings
	always_ff @(posedge i_clk)
		if (i_wipe)
			dev_q <= '0;
		else if (i_dev_save)
			dev_q <= i_dev_wdata;

	assign o_valid = valid_q;
	assign o_fav = fav_q;
	assign o_rd_data = mem_q[i_slot];
	assign o_dev_data = dev_q;
endmodule : osk_setup_store

// File: hdl/osk_top.sv
// The register offsets and the AXI4-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`include "osk_regs.svh"
module osk_top
	import osk_pkg::*;
#(
	parameter int VW = 16,
	parameter logic [31:0] CYCLES_PER_MIN = 32'(64'(`OSK_MIN_SEC) * 64'(`OSK_CLK_HZ))
)
(
	input wire logic I_CLK, // 50 MHz system clock
	input wire logic I_RST_N, // synchronous reset, reboot
	input wire logic I_POWER_ON, // wipes retained setups
	input wire logic [`OSK_ADDR_W-1:0] AWADDR, // axi write address
	input wire logic AWVALID, // axi
	output logic AWREADY, // axi
	input wire logic [31:0] WDATA, // axi
	input wire logic [3:0] WSTRB, // axi
	input wire logic WVALID, // axi
	output logic WREADY, // axi
	output logic [1:0] BRESP, // axi
	output logic BVALID, // axi
	input wire logic BREADY, // axi
	input wire logic [`OSK_ADDR_W-1:0] ARADDR, // axi read address
	input wire logic ARVALID, // axi
	output logic ARREADY, // axi
	output logic [31:0] RDATA, // axi
	output logic [1:0] RRESP, // axi
	output logic RVALID, // axi
	input wire logic RREADY, // axi
	input wire logic [VW-1:0] I_MEAS_VALUE, // measured value
	input wire logic I_MEAS_VALID, // new value pulse
	input wire logic [VW-1:0] I_PEAK_START, // detected peak first pixel
	input wire logic [VW-1:0] I_PEAK_END, // detected peak last pixel
	input wire logic I_KEY_N, // front key pin, low pressed
	output logic O_SWITCH_OUT, // switching output level
	output logic O_SWITCH_OE, // switching output driven
	output logic [VW-1:0] O_SER_VALUE, // serial line value
	output logic O_SER_VALID, // serial line value pulse
	output logic [VW-1:0] O_CUR_VALUE, // current output value
	output logic O_CUR_VALID, // current output update pulse
	output logic [VW-1:0] O_WEB_VALUE, // web chart value
	output logic O_WEB_VALID, // web chart value pulse
	output logic O_UNIT_INCH, // web display in inches
	output logic O_LED_YELLOW, // web selected
	output logic O_LED_GREEN, // serial selected
	output logic O_LED_RED, // analog selected
	output logic O_KEY_PRESS, // accepted key press pulse
	output logic O_KEY_LOCKED, // key currently locked
	output logic [31:0] O_ACTIVE_CFG // active measurement setup
);
	localparam logic [5:0] MIN_LO = `OSK_LOCK_MIN_LO;
	localparam logic [5:0] MIN_HI = `OSK_LOCK_MIN_HI;

	if (VW < 2 || VW > 16 || CYCLES_PER_MIN < 32'h1) begin : g_chk
		$error("osk_top: unsupported parameters");
	end

	function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
		input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = n[b*8 +: 8];
		return r;
	endfunction : merge

	function automatic logic mapped(input logic [`OSK_ADDR_W-1:0] a);
		return a == `OSK_A_CTRL || a == `OSK_A_LIMIT || a == `OSK_A_HOLD ||
			a == `OSK_A_ARANGE || a == `OSK_A_WINDOW || a == `OSK_A_LOCK ||
			a == `OSK_A_CMD || a == `OSK_A_STATUS || a == `OSK_A_MEAS ||
			a == `OSK_A_ACTIVE;
	endfunction : mapped

	logic [31:0] ctrl_q, limit_q, hold_q, arange_q, window_q, lock_q, meas_q, active_q;
	logic bvalid_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic wr_go, rd_go, cmd_go;
	logic [31:0] cmd;
	osk_state_t state_q;
	logic [7:0] slot_valid;
	logic [2:0] fav_slot;
	logic [31:0] slot_data, dev_data;
	logic [2:0] slot_sel;

	// axi handshakes: both write halves taken in the same cycle
	assign wr_go = AWVALID && WVALID && !bvalid_q;
	assign AWREADY = wr_go;
	assign WREADY = wr_go;
	assign rd_go = ARVALID && !rvalid_q;
	assign ARREADY = rd_go;
	assign cmd_go = wr_go && AWADDR == `OSK_A_CMD && state_q == ST_RUN;
	assign cmd = merge(32'h0, WDATA, WSTRB);

	always_ff @(posedge I_CLK)
		if (!I_RST_N)
		begin
			bvalid_q <= 1'b0;
			bresp_q <= `OSK_RESP_OKAY;
		end
		else if (wr_go)
		begin
			bvalid_q <= 1'b1;
			bresp_q <= mapped(AWADDR) ? `OSK_RESP_OKAY : `OSK_RESP_SLVERR;
		end
		else if (BREADY)
			bvalid_q <= 1'b0;

	assign BVALID = bvalid_q;
	assign BRESP = bresp_q;

	osk_swmode_t mode;
	osk_drive_t drive;
	osk_sel_t sel;
	osk_lock_t lock_mode;
	assign mode = osk_swmode_t'(ctrl_q[`OSK_F_MODE]);
	assign drive = osk_drive_t'(ctrl_q[`OSK_F_DRIVE]);
	assign sel = osk_sel_t'(ctrl_q[`OSK_F_SEL]);
	assign lock_mode = osk_lock_t'(ctrl_q[`OSK_F_LOCK]);

	// R14 device settings reload
	always_ff @(posedge I_CLK)
		if (!I_RST_N)
			ctrl_q <= `OSK_CTRL_RST;
		else if (cmd_go && cmd[`OSK_C_DEV_LOAD])
			ctrl_q <= {23'h0, dev_data[`OSK_F_CTRL_W-1:0]};
		else if (wr_go && AWADDR == `OSK_A_CTRL)
			ctrl_q <= merge(ctrl_q, WDATA, WSTRB) & 32'h000001ff;

	always_ff @(posedge I_CLK)
		if (!I_RST_N)
		begin
			limit_q <= '0;
			hold_q <= '0;
			arange_q <= '0;
			window_q <= '0;
			lock_q <= `OSK_LOCK_RST;
			meas_q <= '0;
		end
		else if (wr_go)
			case (AWADDR)
				`OSK_A_LIMIT: limit_q <= merge(limit_q, WDATA, WSTRB);
				`OSK_A_HOLD: hold_q <= merge(hold_q, WDATA, WSTRB);
				`OSK_A_ARANGE: arange_q <= merge(arange_q, WDATA, WSTRB);
				`OSK_A_WINDOW: window_q <= merge(window_q, WDATA, WSTRB);
				`OSK_A_LOCK: lock_q <= merge(lock_q, WDATA, WSTRB) & 32'h0000003f;
				`OSK_A_MEAS: meas_q <= merge(meas_q, WDATA, WSTRB);
				default: ;
			endcase

	// R11 eight slots, one selected per command
	assign slot_sel = state_q == ST_BOOT ? fav_slot : cmd[`OSK_C_SLOT];

	osk_setup_store #(.SLOTS(8), .DW(32)) u_store (
		.i_clk(I_CLK),
		.i_wipe(I_POWER_ON),
		.i_create(cmd_go && cmd[`OSK_C_CREATE]),
		.i_save(cmd_go && cmd[`OSK_C_SAVE]),
		.i_delete(cmd_go && cmd[`OSK_C_DELETE]),
		.i_fav(cmd_go && cmd[`OSK_C_FAV]),
		.i_slot(slot_sel),
		.i_wdata(meas_q),
		.i_dev_save(cmd_go && cmd[`OSK_C_DEV_SAVE]),
		.i_dev_wdata(ctrl_q),
		.o_valid(slot_valid),
		.o_fav(fav_slot),
		.o_rd_data(slot_data),
		.o_dev_data(dev_data)
	);

	// R13 boot from favourite, R11 load
	always_ff @(posedge I_CLK)
		if (!I_RST_N)
		begin
			state_q <= ST_BOOT;
			active_q <= '0;
		end
		else
			case (state_q)
				ST_BOOT:
				begin
					if (slot_valid[fav_slot])
						active_q <= slot_data;
					state_q <= ST_RUN;
				end
				ST_RUN:
					if (cmd_go && cmd[`OSK_C_LOAD] && slot_valid[slot_sel])
						active_q <= slot_data;
				default: state_q <= ST_BOOT;
			endcase

	assign O_ACTIVE_CFG = active_q;

	logic [VW-1:0] val, lim, hys, rel, a_lo, a_hi, w_lo, w_hi;
	logic sw_q, lim_q, sw;
	logic [31:0] hold_cnt_q;
	assign val = I_MEAS_VALUE;
	assign lim = limit_q[VW-1:0];
	assign hys = limit_q[16 +: VW];
	assign rel = hys > lim ? '0 : lim - hys;
	assign a_lo = arange_q[VW-1:0];
	assign a_hi = arange_q[16 +: VW];
	assign w_lo = window_q[VW-1:0];
	assign w_hi = window_q[16 +: VW];

	// R2 set above limit, R16 release with hysteresis after hold
	always_ff @(posedge I_CLK)
		if (!I_RST_N || mode != SW_LIMIT)
		begin
			lim_q <= 1'b0;
			hold_cnt_q <= '0;
		end
		else if (I_MEAS_VALID && val > lim)
		begin
			lim_q <= 1'b1;
			hold_cnt_q <= hold_q;
		end
		else
		begin
			if (hold_cnt_q != '0)
				hold_cnt_q <= hold_cnt_q - 32'h1;
			else if (I_MEAS_VALID && val < rel)
				lim_q <= 1'b0;
		end

	always_ff @(posedge I_CLK)
		if (!I_RST_N)
			sw_q <= 1'b0;
		else
			case (mode)
				// R1 peak partly outside window
				SW_WINDOW: if (I_MEAS_VALID)
					sw_q <= I_PEAK_START < w_lo || I_PEAK_END > w_hi;
				// R3 outside scaled analog range
				SW_ANALOG: if (I_MEAS_VALID)
					sw_q <= val < a_lo || val > a_hi;
				SW_LIMIT: sw_q <= lim_q;
				default: sw_q <= 1'b0;
			endcase

	// limit latch reaches the pin without an extra cycle
	assign sw = mode == SW_LIMIT ? lim_q : sw_q;

	// R2 selectable output stage
	assign O_SWITCH_OE = drive == DRV_NPN || drive == DRV_PNP ? sw : 1'b1;
	assign O_SWITCH_OUT = drive == DRV_NPN ? 1'b0 : drive == DRV_PNP ? 1'b1 :
		drive == DRV_PUSH ? sw : !sw;

	logic [VW-1:0] ser_q, cur_q, web_q;
	logic ser_v_q, cur_v_q, web_v_q;
	// R5 exclusive routing, R6 web silences both lines
	always_ff @(posedge I_CLK)
		if (!I_RST_N)
		begin
			ser_q <= '0;
			cur_q <= '0;
			web_q <= '0;
			ser_v_q <= 1'b0;
			cur_v_q <= 1'b0;
			web_v_q <= 1'b0;
		end
		else
		begin
			ser_v_q <= I_MEAS_VALID && sel == SEL_SERIAL;
			cur_v_q <= I_MEAS_VALID && sel == SEL_ANALOG;
			web_v_q <= I_MEAS_VALID && sel != SEL_SERIAL;
			if (I_MEAS_VALID)
			begin
				ser_q <= sel == SEL_SERIAL ? val : '0;
				cur_q <= sel == SEL_ANALOG ? val : '0;
				web_q <= sel != SEL_SERIAL ? val : '0;
			end
		end

	assign O_SER_VALUE = ser_q;
	assign O_SER_VALID = ser_v_q;
	assign O_CUR_VALUE = cur_q;
	assign O_CUR_VALID = cur_v_q;
	assign O_WEB_VALUE = web_q;
	assign O_WEB_VALID = web_v_q;
	// R15 display unit
	assign O_UNIT_INCH = ctrl_q[`OSK_F_INCH];
	// R4 status led colour
	assign O_LED_YELLOW = sel == SEL_WEB;
	assign O_LED_GREEN = sel == SEL_SERIAL;
	assign O_LED_RED = sel == SEL_ANALOG;

	logic key_s1_q, key_s2_q, key_prev_q, press, locked, auto_lk_q, refresh;
	logic [31:0] cyc_q;
	logic [5:0] min_q, interval;
	always_ff @(posedge I_CLK)
		if (!I_RST_N)
		begin
			key_s1_q <= 1'b1;
			key_s2_q <= 1'b1;
			key_prev_q <= 1'b1;
		end
		else
		begin
			key_s1_q <= I_KEY_N;
			key_s2_q <= key_s1_q;
			key_prev_q <= key_s2_q;
		end

	assign press = key_prev_q && !key_s2_q;
	assign interval = lock_q[`OSK_F_MIN] < MIN_LO ? MIN_LO :
		lock_q[`OSK_F_MIN] > MIN_HI ? MIN_HI : lock_q[`OSK_F_MIN];
	assign refresh = cmd_go && cmd[`OSK_C_REFRESH];

	// R7 idle interval, R8 refresh restarts it
	always_ff @(posedge I_CLK)
		if (!I_RST_N || lock_mode != LK_AUTO || refresh || (press && !auto_lk_q))
		begin
			cyc_q <= '0;
			min_q <= '0;
			auto_lk_q <= 1'b0;
		end
		else if (!auto_lk_q)
		begin
			if (cyc_q >= CYCLES_PER_MIN - 32'h1)
			begin
				cyc_q <= '0;
				min_q <= min_q + 6'h1;
				if (min_q + 6'h1 >= interval)
					auto_lk_q <= 1'b1;
			end
			else
				cyc_q <= cyc_q + 32'h1;
		end

	// R9 permanent lock, R10 never locked
	assign locked = lock_mode == LK_ON || (lock_mode == LK_AUTO && auto_lk_q);
	assign O_KEY_LOCKED = locked;

	logic press_q;
	always_ff @(posedge I_CLK)
		if (!I_RST_N)
			press_q <= 1'b0;
		else
			press_q <= press && !locked;
	assign O_KEY_PRESS = press_q;

	logic [31:0] rd_mux;
	always_comb
		case (ARADDR)
			`OSK_A_CTRL: rd_mux = ctrl_q;
			`OSK_A_LIMIT: rd_mux = limit_q;
			`OSK_A_HOLD: rd_mux = hold_q;
			`OSK_A_ARANGE: rd_mux = arange_q;
			`OSK_A_WINDOW: rd_mux = window_q;
			`OSK_A_LOCK: rd_mux = lock_q;
			`OSK_A_STATUS: rd_mux = {16'h0, fav_slot, slot_valid, 2'h0, locked, sw, lim_q};
			`OSK_A_MEAS: rd_mux = meas_q;
			`OSK_A_ACTIVE: rd_mux = active_q;
			default: rd_mux = 32'h0;
		endcase

	always_ff @(posedge I_CLK)
		if (!I_RST_N)
		begin
			rvalid_q <= 1'b0;
			rdata_q <= '0;
			rresp_q <= `OSK_RESP_OKAY;
		end
		else if (rd_go)
		begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_mux;
			rresp_q <= mapped(ARADDR) ? `OSK_RESP_OKAY : `OSK_RESP_SLVERR;
		end
		else if (RREADY)
			rvalid_q <= 1'b0;

	assign RVALID = rvalid_q;
	assign RDATA = rdata_q;
	assign RRESP = rresp_q;
endmodule : osk_top

// File: tb/osk_pc_model.sv
`timescale 1ns/1ps
// controller side: counts the values each interface delivers
module osk_pc_model (
	input wire logic i_clk, // system clock
	input wire logic i_ser_valid, // serial value pulse
	input wire logic [15:0] i_ser_value, // serial value
	input wire logic i_cur_valid, // current output pulse
	input wire logic [15:0] i_cur_value, // current output value
	input wire logic i_web_valid, // web chart pulse
	output int o_n_ser, // serial values seen
	output int o_n_cur, // current values seen
	output int o_n_web, // web values seen
	output logic [15:0] o_last // last serial or current value
);
	always @(posedge i_clk)
	begin
		if (i_ser_valid === 1'h1)
		begin
			o_n_ser <= o_n_ser + 1;
			o_last <= i_ser_value;
		end
		if (i_cur_valid === 1'h1)
		begin
			o_n_cur <= o_n_cur + 1;
			o_last <= i_cur_value;
		end
		if (i_web_valid === 1'h1)
			o_n_web <= o_n_web + 1;
	end
endmodule : osk_pc_model

// File: tb/osk_top_assertions.sv
`timescale 1ns/1ps
module osk_top_checker #(
	parameter int VW = 16
)
(
	input wire logic I_CLK, // clock
	input wire logic I_RST_N, // reset
	input wire logic BVALID, // write answer
	input wire logic I_MEAS_VALID, // value pulse
	input wire logic [VW-1:0] I_MEAS_VALUE, // value
	input wire logic I_KEY_N, // key pin
	input wire logic O_SER_VALID, // serial pulse
	input wire logic [VW-1:0] O_SER_VALUE, // serial value
	input wire logic O_CUR_VALID, // current pulse
	input wire logic O_WEB_VALID, // web pulse
	input wire logic O_LED_YELLOW, // led
	input wire logic O_LED_GREEN, // led
	input wire logic O_LED_RED, // led
	input wire logic O_SWITCH_OE, // switch enable
	input wire logic O_KEY_PRESS, // accepted press
	input wire logic O_KEY_LOCKED // key locked
);
	default clocking cb @(posedge I_CLK);
	endclocking
	default disable iff (!I_RST_N);
	property p_excl;
		!(O_SER_VALID && O_CUR_VALID);
	endproperty
	a_excl: assert property (p_excl) else $error("serial and current together");
	property p_ser;
		I_MEAS_VALID && O_LED_GREEN |=> O_SER_VALID && (O_SER_VALUE == $past(I_MEAS_VALUE));
	endproperty
	a_ser: assert property (p_ser) else $error("serial value missing");
	property p_cur;
		O_CUR_VALID |-> O_LED_RED && $past(I_MEAS_VALID);
	endproperty
	a_cur: assert property (p_cur) else $error("current output unselected");
	property p_web;
		I_MEAS_VALID && O_LED_YELLOW |=> O_WEB_VALID && !O_SER_VALID && !O_CUR_VALID;
	endproperty
	a_web: assert property (p_web) else $error("web selection leaks");
	property p_led;
		$onehot0({O_LED_YELLOW, O_LED_GREEN, O_LED_RED});
	endproperty
	a_led: assert property (p_led) else $error("several led colours");
	property p_sw;
		$changed(O_SWITCH_OE) |-> $past(I_MEAS_VALID) || BVALID || $past(BVALID);
	endproperty
	a_sw: assert property (p_sw) else $error("switch moved without cause");
	property p_kl;
		O_KEY_PRESS |-> !$past(O_KEY_LOCKED);
	endproperty
	a_kl: assert property (p_kl) else $error("press taken while locked");
	property p_ka;
		$fell(I_KEY_N) && !O_KEY_LOCKED |-> ##[1:6] (O_KEY_PRESS || O_KEY_LOCKED);
	endproperty
	a_ka: assert property (p_ka) else $error("press not accepted");
	c_ser: cover property (O_SER_VALID);
	c_cur: cover property (O_CUR_VALID);
	c_lock: cover property ($rose(O_KEY_LOCKED));
endmodule : osk_top_checker
bind osk_top osk_top_checker #(.VW(VW)) u_chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
	.BVALID(BVALID), .I_MEAS_VALID(I_MEAS_VALID), .I_MEAS_VALUE(I_MEAS_VALUE),
	.I_KEY_N(I_KEY_N), .O_SER_VALID(O_SER_VALID), .O_SER_VALUE(O_SER_VALUE),
	.O_CUR_VALID(O_CUR_VALID), .O_WEB_VALID(O_WEB_VALID), .O_LED_YELLOW(O_LED_YELLOW),
	.O_LED_GREEN(O_LED_GREEN), .O_LED_RED(O_LED_RED), .O_SWITCH_OE(O_SWITCH_OE),
	.O_KEY_PRESS(O_KEY_PRESS), .O_KEY_LOCKED(O_KEY_LOCKED));

// File: tb/testbench.sv
`timescale 1ns/1ps
`include "osk_regs.svh"
module testbench;
	logic I_CLK = 1'h0, I_RST_N = 1'h0, I_POWER_ON = 1'h1, I_KEY_N = 1'h1, I_MEAS_VALID = 1'h0;
	logic AWVALID = 1'h0, WVALID = 1'h0, BREADY = 1'h0, ARVALID = 1'h0, RREADY = 1'h0;
	logic [7:0] AWADDR = 8'h0, ARADDR = 8'h0;
	logic [31:0] WDATA = 32'h0, RDATA, O_ACTIVE_CFG, rd;
	logic [15:0] I_MEAS_VALUE = 16'h0, I_PEAK_START = 16'h0, I_PEAK_END = 16'h0;
	logic [15:0] O_SER_VALUE, O_CUR_VALUE, O_WEB_VALUE, last;
	logic [1:0] BRESP, RRESP, resp;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID, O_SWITCH_OUT, O_SWITCH_OE, O_SER_VALID;
	logic O_CUR_VALID, O_WEB_VALID, O_UNIT_INCH, O_LED_YELLOW, O_LED_GREEN, O_LED_RED;
	logic O_KEY_PRESS, O_KEY_LOCKED, got;
	int mismatches = 0, n_compared = 0, cyc = 0, ns, nc, nw, ps, pc, pw;
	always #10 I_CLK = ~I_CLK;
	osk_top #(.CYCLES_PER_MIN(32'h14)) dut (.I_CLK(I_CLK), .I_RST_N(I_RST_N),
		.I_POWER_ON(I_POWER_ON), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
		.WDATA(WDATA), .WSTRB(4'hf), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
		.BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
		.ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
		.I_MEAS_VALUE(I_MEAS_VALUE), .I_MEAS_VALID(I_MEAS_VALID), .I_PEAK_START(I_PEAK_START),
		.I_PEAK_END(I_PEAK_END), .I_KEY_N(I_KEY_N), .O_SWITCH_OUT(O_SWITCH_OUT),
		.O_SWITCH_OE(O_SWITCH_OE), .O_SER_VALUE(O_SER_VALUE), .O_SER_VALID(O_SER_VALID),
		.O_CUR_VALUE(O_CUR_VALUE), .O_CUR_VALID(O_CUR_VALID), .O_WEB_VALUE(O_WEB_VALUE),
		.O_WEB_VALID(O_WEB_VALID), .O_UNIT_INCH(O_UNIT_INCH), .O_LED_YELLOW(O_LED_YELLOW),
		.O_LED_GREEN(O_LED_GREEN), .O_LED_RED(O_LED_RED), .O_KEY_PRESS(O_KEY_PRESS),
		.O_KEY_LOCKED(O_KEY_LOCKED), .O_ACTIVE_CFG(O_ACTIVE_CFG));
	osk_pc_model u_pc (.i_clk(I_CLK), .i_ser_valid(O_SER_VALID), .i_ser_value(O_SER_VALUE),
		.i_cur_valid(O_CUR_VALID), .i_cur_value(O_CUR_VALUE), .i_web_valid(O_WEB_VALID),
		.o_n_ser(ns), .o_n_cur(nc), .o_n_web(nw), .o_last(last));
	task automatic complete_run();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : complete_run
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	// readies are stable from the falling edge up to the sampling edge
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'h1;
		WVALID <= 1'h1;
		BREADY <= 1'h1;
		got = 1'h0;
		while (!got)
		begin
			@(negedge I_CLK);
			got = AWREADY && WREADY;
			@(posedge I_CLK);
		end
		AWVALID <= 1'h0;
		WVALID <= 1'h0;
		got = 1'h0;
		while (!got)
		begin
			@(negedge I_CLK);
			got = BVALID;
			resp = BRESP;
			@(posedge I_CLK);
		end
		BREADY <= 1'h0;
		@(posedge I_CLK);
	endtask : wr
	task automatic rdr(input logic [7:0] a);
		ARADDR <= a;
		ARVALID <= 1'h1;
		RREADY <= 1'h1;
		got = 1'h0;
		while (!got)
		begin
			@(negedge I_CLK);
			got = ARREADY;
			@(posedge I_CLK);
		end
		ARVALID <= 1'h0;
		got = 1'h0;
		while (!got)
		begin
			@(negedge I_CLK);
			got = RVALID;
			rd = RDATA;
			resp = RRESP;
			@(posedge I_CLK);
		end
		RREADY <= 1'h0;
		@(posedge I_CLK);
	endtask : rdr
	task automatic mv(input logic [15:0] v, input logic [15:0] s, input logic [15:0] e);
		I_MEAS_VALUE <= v;
		I_PEAK_START <= s;
		I_PEAK_END <= e;
		I_MEAS_VALID <= 1'h1;
		@(posedge I_CLK);
		I_MEAS_VALID <= 1'h0;
		repeat (2) @(posedge I_CLK);
	endtask : mv
	task automatic swc(input logic [15:0] v, s, e, input logic [1:0] ex);
		mv(v, s, e);
		chk("switch", {O_SWITCH_OE, O_SWITCH_OUT}, ex);
	endtask : swc
	task automatic key(output logic acc);
		I_KEY_N <= 1'h0;
		acc = 1'h0;
		repeat (8)
		begin
			@(posedge I_CLK);
			#1 acc = acc | (O_KEY_PRESS === 1'h1);
		end
		@(posedge I_CLK);
		I_KEY_N <= 1'h1;
		repeat (6) @(posedge I_CLK);
	endtask : key
	task automatic lk(input logic e);
		chk("locked", O_KEY_LOCKED, e);
	endtask : lk
	always @(posedge I_CLK)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			mismatches++;
			complete_run();
		end
	end
	initial
	begin
		repeat (5) @(posedge I_CLK);
		I_RST_N <= 1'h1;
		I_POWER_ON <= 1'h0;
		repeat (3) @(posedge I_CLK);
		wr(8'h40, 32'h1);
		chk("bresp", resp, `OSK_RESP_SLVERR);
		rdr(8'h40);
		chk("rresp", resp, `OSK_RESP_SLVERR);
		chk("rdata", rd, 32'h0);
		$display("test bus done");
		for (int s = 0; s < 3; s++)
		begin
			wr(`OSK_A_CTRL, 32'(s) << 4);
			ps = ns;
			pc = nc;
			pw = nw;
			mv(16'h0100 + 16'(s), 16'h0, 16'h0);
			chk("led", {O_LED_YELLOW, O_LED_GREEN, O_LED_RED}, 3'h4 >> s);
			chk("sent", {1'(ns - ps), 1'(nc - pc), 1'(nw - pw)}, {s == 1, s == 2, s != 1});
			if (s != 0)
				chk("line value", last, 16'h0100 + 16'(s));
			if (s != 1)
				chk("web value", O_WEB_VALUE, 16'h0100 + 16'(s));
		end
		$display("test select done");
		wr(`OSK_A_WINDOW, 32'h0064000a);
		wr(`OSK_A_CTRL, 32'h9);
		swc(16'h0, 16'h14, 16'h1e, 2'h2);
		swc(16'h0, 16'h5, 16'h1e, 2'h3);
		swc(16'h0, 16'h5f, 16'h78, 2'h3);
		swc(16'h0, 16'h28, 16'h32, 2'h2);
		wr(`OSK_A_ARANGE, 32'h0064000a);
		wr(`OSK_A_CTRL, 32'ha);
		swc(16'h32, 16'h0, 16'h0, 2'h2);
		swc(16'h96, 16'h0, 16'h0, 2'h3);
		swc(16'h5, 16'h0, 16'h0, 2'h3);
		wr(`OSK_A_LIMIT, 32'h000a0064);
		wr(`OSK_A_HOLD, 32'h4);
		wr(`OSK_A_CTRL, 32'hf);
		swc(16'h78, 16'h0, 16'h0, 2'h2);
		swc(16'h5f, 16'h0, 16'h0, 2'h2);
		swc(16'h50, 16'h0, 16'h0, 2'h3);
		wr(`OSK_A_CTRL, 32'h3);
		swc(16'h78, 16'h0, 16'h0, 2'h2);
		swc(16'h50, 16'h0, 16'h0, 2'h2);
		swc(16'h50, 16'h0, 16'h0, 2'h0);
		$display("test switch done");
		wr(`OSK_A_CTRL, 32'h0);
		key(got);
		chk("accepted", got, 1'h1);
		wr(`OSK_A_CTRL, 32'h80);
		lk(1'h1);
		key(got);
		chk("ignored", got, 1'h0);
		wr(`OSK_A_LOCK, 32'h0);
		rdr(`OSK_A_LOCK);
		chk("minutes", rd, 32'h0);
		wr(`OSK_A_LOCK, 32'h3f);
		rdr(`OSK_A_LOCK);
		chk("minutes", rd, 32'h3f);
		wr(`OSK_A_LOCK, 32'h0);
		wr(`OSK_A_CTRL, 32'h100);
		repeat (12) @(posedge I_CLK);
		lk(1'h0);
		repeat (14) @(posedge I_CLK);
		lk(1'h1);
		wr(`OSK_A_CMD, 32'h1);
		lk(1'h0);
		repeat (12) @(posedge I_CLK);
		wr(`OSK_A_CMD, 32'h1);
		repeat (12) @(posedge I_CLK);
		lk(1'h0);
		repeat (12) @(posedge I_CLK);
		lk(1'h1);
		$display("test lock done");
		wr(`OSK_A_MEAS, 32'h1234);
		wr(`OSK_A_CMD, 32'h320);
		rdr(`OSK_A_STATUS);
		chk("slots", rd[12:5], 8'h08);
		wr(`OSK_A_CMD, 32'h504);
		rdr(`OSK_A_STATUS);
		chk("slots", rd[12:5], 8'h08);
		wr(`OSK_A_MEAS, 32'h5678);
		wr(`OSK_A_CMD, 32'h304);
		wr(`OSK_A_CMD, 32'h302);
		rdr(`OSK_A_ACTIVE);
		chk("active", rd, 32'h5678);
		chk("active", O_ACTIVE_CFG, 32'h5678);
		wr(`OSK_A_CMD, 32'h308);
		rdr(`OSK_A_STATUS);
		chk("slots", rd[12:5], 8'h00);
		wr(`OSK_A_MEAS, 32'habcd);
		wr(`OSK_A_CMD, 32'h720);
		wr(`OSK_A_CMD, 32'h710);
		rdr(`OSK_A_STATUS);
		chk("favourite", rd[15:13], 3'h7);
		wr(`OSK_A_CTRL, 32'h41);
		chk("inch", O_UNIT_INCH, 1'h1);
		wr(`OSK_A_CMD, 32'h40);
		wr(`OSK_A_CTRL, 32'h0);
		chk("inch", O_UNIT_INCH, 1'h0);
		I_RST_N <= 1'h0;
		repeat (5) @(posedge I_CLK);
		I_RST_N <= 1'h1;
		repeat (3) @(posedge I_CLK);
		chk("reboot", O_ACTIVE_CFG, 32'habcd);
		wr(`OSK_A_CMD, 32'h80);
		rdr(`OSK_A_CTRL);
		chk("device", rd, 32'h41);
		$display("test store done");
		complete_run();
	end
endmodule : testbench
